// ---- dpw_pkg.sv ----
// Package for the dual wiper command interpreter: codes, layouts, timing
package dpw_pkg;

  localparam int          DPW_WIDTH      = 8;
  localparam logic [7:0]  DPW_MIDSCALE   = 8'h80;
  localparam logic [1:0]  DPW_CMD_WIPER  = 2'h0;
  localparam logic [1:0]  DPW_CMD_NVWR   = 2'h1;
  localparam logic [1:0]  DPW_CMD_COPY   = 2'h2;
  localparam logic [1:0]  DPW_CMD_REST   = 2'h3;
  localparam logic [4:0]  DPW_EDGES_FULL = 5'h10;
  localparam logic [4:0]  DPW_EDGES_HALF = 5'h08;
  // Frame bit positions within the 16-bit shift word, edge 1 at bit 15
  localparam int          DPW_CMD_HI     = 13;
  localparam int          DPW_SEL_HI     = 9;
  localparam int          DPW_DAT_HI     = 7;
  localparam int          DPW_INIT_NS    = 5000;
  localparam int          DPW_CLK_NS     = 10;
  localparam int          DPW_INIT_CYC   = DPW_INIT_NS / DPW_CLK_NS;
  localparam logic [9:0]  DPW_INIT_CNT   = 10'(DPW_INIT_CYC);

  typedef struct packed {
    logic       csn;
    logic       sclk;
    logic       din;
  } dpw_pins_t;

  typedef struct packed {
    logic [1:0] cmd;
    logic [1:0] sel;
    logic [7:0] data;
    logic       full;
  } dpw_frame_t;

endpackage

// ---- dpw_sync.sv ----
// Two-flop synchroniser for the serial pins
`timescale 1ns/1ps
module dpw_sync
  import dpw_pkg::*;
(
  // Clock and reset
  input  wire logic      i_clk,
  input  wire logic      i_resetn,
  input  wire logic      i_ce,
  // Pins in, synchronised out
  input  wire dpw_pins_t i_pins,
  output dpw_pins_t      o_pins
);

  typedef struct packed {
    dpw_pins_t s1;
    dpw_pins_t s2;
  } dpw_sync_t;

  dpw_sync_t st_ff;
  dpw_sync_t nxt_st;

  always_comb begin
    nxt_st    = st_ff;
    nxt_st.s1 = i_pins;
    nxt_st.s2 = st_ff.s1;
  end

  // Idle pins: chip select high
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_ff <= '{s1: 3'h4, s2: 3'h4};
    end else if (i_ce) begin
      st_ff <= nxt_st;
    end
  end

  assign o_pins = st_ff.s2;

endmodule

// ---- dpw_core.sv ----
// Serial command interpreter for two wiper and two nonvolatile registers
// Operation
// - NV-write command stores data into selected NV
// - NV-write leaves wiper registers unchanged
// - Copy command moves wiper into NV
// - Copy applies to A, B, or both
// - Restore loads selected wipers from NV
// - NV starts midscale, retained across power-down
// - Power-up copies NV into wipers within 5us
// - Standby whenever no transfer in progress, once initialisation ends
// - Writes need 16 edges; copies 8 or 16
// - Chip select rise executes frame, disables input
// - Wiper write updates only selected wiper
// - Frame layout command, select, data, MSB first
`timescale 1ns/1ps
module dpw_core
  import dpw_pkg::*;
#(
  parameter int INIT_CYC = DPW_INIT_CYC
)
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  input  wire logic       i_ce,
  // Serial pins
  input  wire logic       i_csn,
  input  wire logic       i_sclk,
  input  wire logic       i_din,
  // Nonvolatile image held outside this block, presented at power-up
  input  wire logic [7:0] i_nv_a,
  input  wire logic [7:0] i_nv_b,
  // Register contents and status
  output logic [7:0]      o_wiper_a,
  output logic [7:0]      o_wiper_b,
  output logic [7:0]      o_nv_a,
  output logic [7:0]      o_nv_b,
  output logic            o_nv_store,
  output logic            o_ready,
  output logic            o_standby
);

  // Wipers need one edge to follow the freshly loaded image, so two edges at least
  if (INIT_CYC < 2 || INIT_CYC > 1023) begin : g_bad_init
    $error("INIT_CYC out of range");
  end

  typedef enum logic [1:0] {
    ST_INIT  = 2'b00,
    ST_IDLE  = 2'b01,
    ST_SHIFT = 2'b10
  } dpw_state_t;

  typedef struct packed {
    dpw_state_t  state;
    logic [9:0]  init_cnt;
    logic [15:0] shreg;
    logic [4:0]  edges;
    logic        sclk_d;
    logic [7:0]  wiper_a;
    logic [7:0]  wiper_b;
    logic [7:0]  nv_a;
    logic [7:0]  nv_b;
    logic        nv_store;
    logic        ready;
    logic        standby;
    logic        cap;
  } dpw_core_t;

  dpw_core_t  st_ff;
  dpw_core_t  nxt_st;
  dpw_pins_t  pins;
  dpw_frame_t frm;
  logic       sel_a;
  logic       sel_b;
  logic       done;
  logic       valid;

  dpw_sync u_sync (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_ce     (i_ce),
    .i_pins   ({i_csn, i_sclk, i_din}),
    .o_pins   (pins)
  );

  // Slice the shift word by the count of edges received
  function automatic dpw_frame_t decode(input logic [15:0] sh, input logic [4:0] n);
    dpw_frame_t f;
    logic [15:0] w;
    f = '0;
    w = (n == DPW_EDGES_HALF) ? {sh[7:0], 8'h00} : sh;
    f.cmd  = w[DPW_CMD_HI -: 2];
    f.sel  = w[DPW_SEL_HI -: 2];
    f.data = w[DPW_DAT_HI -: 8];
    f.full = (n == DPW_EDGES_FULL);
    return f;
  endfunction

  always_comb begin
    frm   = decode(st_ff.shreg, st_ff.edges);
    sel_a = frm.sel[0];
    sel_b = frm.sel[1];
    // Writes need the full frame, copies accept either length
    valid = frm.full || (st_ff.edges == DPW_EDGES_HALF && frm.cmd[1]);
    done  = (st_ff.state == ST_SHIFT) && pins.csn;
    nxt_st          = st_ff;
    nxt_st.sclk_d   = pins.sclk;
    nxt_st.nv_store = 1'b0;
    unique case (st_ff.state)
      ST_INIT: begin
        // Wipers follow NV while the initialisation period runs
        nxt_st.wiper_a  = st_ff.nv_a;
        nxt_st.wiper_b  = st_ff.nv_b;
        nxt_st.init_cnt = st_ff.init_cnt - 10'h001;
        if (st_ff.init_cnt == 10'h001) begin
          nxt_st.state   = ST_IDLE;
          nxt_st.ready   = 1'b1;
          nxt_st.standby = 1'b1;
        end
      end
      ST_IDLE: begin
        if (!pins.csn) begin
          nxt_st.state   = ST_SHIFT;
          nxt_st.standby = 1'b0;
          nxt_st.edges   = 5'h00;
          nxt_st.shreg   = 16'h0000;
        end
      end
      ST_SHIFT: begin
        if (pins.sclk && !st_ff.sclk_d && st_ff.edges != 5'h1f) begin
          nxt_st.shreg = {st_ff.shreg[14:0], pins.din};
          nxt_st.edges = st_ff.edges + 5'h01;
        end
        if (pins.csn) begin
          // Chip select rise: execute and stop taking bits
          nxt_st.state   = ST_IDLE;
          nxt_st.standby = 1'b1;
          if (valid) begin
            unique case (frm.cmd)
              DPW_CMD_WIPER: begin
                if (sel_a) nxt_st.wiper_a = frm.data;
                if (sel_b) nxt_st.wiper_b = frm.data;
              end
              DPW_CMD_NVWR: begin
                if (sel_a) nxt_st.nv_a = frm.data;
                if (sel_b) nxt_st.nv_b = frm.data;
                nxt_st.nv_store = sel_a | sel_b;
              end
              DPW_CMD_COPY: begin
                if (sel_a) nxt_st.nv_a = st_ff.wiper_a;
                if (sel_b) nxt_st.nv_b = st_ff.wiper_b;
                nxt_st.nv_store = sel_a | sel_b;
              end
              DPW_CMD_REST: begin
                if (sel_a) nxt_st.wiper_a = st_ff.nv_a;
                if (sel_b) nxt_st.wiper_b = st_ff.nv_b;
              end
            endcase
          end
        end
      end
      default: begin
        nxt_st.state = ST_IDLE;
      end
    endcase
    // First enabled edge after reset takes the stored image
    nxt_st.cap = 1'b0;
    if (st_ff.cap) begin
      nxt_st.nv_a = i_nv_a;
      nxt_st.nv_b = i_nv_b;
    end
  end

  // Captures the NV image one edge after release; factory value is midscale
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_ff <= '{state: ST_INIT, init_cnt: 10'(INIT_CYC), shreg: 16'h0000,
                 edges: 5'h00, sclk_d: 1'b0, wiper_a: DPW_MIDSCALE,
                 wiper_b: DPW_MIDSCALE, nv_a: DPW_MIDSCALE, nv_b: DPW_MIDSCALE,
                 nv_store: 1'b0, ready: 1'b0, standby: 1'b0, cap: 1'b1};
    end else if (i_ce) begin
      st_ff <= nxt_st;
    end
  end

  assign o_wiper_a  = st_ff.wiper_a;
  assign o_wiper_b  = st_ff.wiper_b;
  assign o_nv_a     = st_ff.nv_a;
  assign o_nv_b     = st_ff.nv_b;
  assign o_nv_store = st_ff.nv_store;
  assign o_ready    = st_ff.ready;
  assign o_standby  = st_ff.standby;

  chk_nvwr_keeps_wiper: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_ce && done && valid && frm.cmd == DPW_CMD_NVWR) |=>
      (o_wiper_a == $past(o_wiper_a) && o_wiper_b == $past(o_wiper_b)))
    else $error("NV write moved a wiper");
  chk_nvwr_stores_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_ce && done && valid && frm.cmd == DPW_CMD_NVWR && sel_a) |=> o_nv_a == $past(frm.data))
    else $error("NV write lost data");
  chk_copy_to_nv: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_ce && done && valid && frm.cmd == DPW_CMD_COPY && sel_b) |=> o_nv_b == $past(o_wiper_b))
    else $error("Copy to NV failed");
  chk_copy_select: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_ce && done && frm.cmd == DPW_CMD_COPY && !sel_a) |=> $stable(o_nv_a))
    else $error("Copy hit unselected NV");
  chk_restore_wiper: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_ce && done && valid && frm.cmd == DPW_CMD_REST && sel_a) |=> o_wiper_a == $past(o_nv_a))
    else $error("Restore failed");
  chk_init_ready: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_ce && o_ready && !$past(o_ready)) |-> (o_wiper_a == o_nv_a && o_wiper_b == o_nv_b))
    else $error("Init did not load wipers");
  chk_standby_idle: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (st_ff.state == ST_SHIFT) |-> !o_standby)
    else $error("Standby during transfer");
  chk_short_frame: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_ce && done && !valid) |=> ($stable(o_wiper_a) && $stable(o_nv_a) && $stable(o_nv_b)))
    else $error("Short frame changed state");
  chk_wiper_only: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_ce && done && frm.cmd == DPW_CMD_WIPER) |=> ($stable(o_nv_a) && $stable(o_nv_b)))
    else $error("Wiper write touched NV");
  chk_no_select: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_ce && done && frm.sel == 2'h0) |=> ($stable(o_wiper_b) && $stable(o_nv_b)))
    else $error("Select 00 changed state");

endmodule

// ---- dpw_host.sv ----
// Serial host model driving chip select, clock and data
`timescale 1ns/1ps
module dpw_host (
  // Clock
  input  wire logic i_clk,
  // Serial pins
  output logic      o_csn,
  output logic      o_sclk,
  output logic      o_din
);
  initial begin
    o_csn  = 1'b1;
    o_sclk = 1'b0;
    o_din  = 1'b0;
  end
  // Four system cycles per phase, so the synchroniser never misses one
  task automatic send(input logic [15:0] w, input int n);
    o_csn = 1'b0;
    for (int i = 0; i < n; i++) begin
      o_din = w[15-i];
      repeat (4) @(negedge i_clk);
      o_sclk = 1'b1;
      repeat (4) @(negedge i_clk);
      o_sclk = 1'b0;
    end
    o_csn = 1'b1;
    // Released data line must not keep looking valid
    o_din = ~o_din;
    repeat (8) @(negedge i_clk);
  endtask
endmodule

// ---- test_dpw_core.sv ----
// Self-checking bench for the dual wiper command interpreter
`timescale 1ns/1ps
module test_dpw_core;
  import dpw_pkg::*;
  localparam int INIT = 4;
  logic       i_clk;
  logic       i_resetn;
  logic       i_ce;
  logic       csn, sclk, din;
  logic [7:0] i_nv_a, i_nv_b, o_wiper_a, o_wiper_b, o_nv_a, o_nv_b;
  logic       o_nv_store, o_ready, o_standby;
  logic [7:0] ew [2];
  logic [7:0] en [2];
  int         errors = 0, n_compared = 0, n_store = 0, x_store = 0;

  dpw_host u_dpw_host (.i_clk(i_clk), .o_csn(csn), .o_sclk(sclk), .o_din(din));
  dpw_core #(.INIT_CYC(INIT)) u_dpw_core (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_ce(i_ce), .i_csn(csn), .i_sclk(sclk),
    .i_din(din), .i_nv_a(i_nv_a), .i_nv_b(i_nv_b), .o_wiper_a(o_wiper_a),
    .o_wiper_b(o_wiper_b), .o_nv_a(o_nv_a), .o_nv_b(o_nv_b),
    .o_nv_store(o_nv_store), .o_ready(o_ready), .o_standby(o_standby));

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // Sampled mid-cycle, where the one-cycle pulse has settled
  always @(negedge i_clk) begin
    if (o_nv_store === 1'b1) n_store++;
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check_all();
    check("wiper_a", o_wiper_a, ew[0]);
    check("wiper_b", o_wiper_b, ew[1]);
    check("nv_a", o_nv_a, en[0]);
    check("nv_b", o_nv_b, en[1]);
    check("stores", 8'(n_store), 8'(x_store));
  endtask
  // Sends one frame and moves the expected registers as the command says
  task automatic go(input logic [1:0] c, input logic [1:0] s, input logic [7:0] d,
                    input int n);
    u_dpw_host.send({2'h0, c, 2'h0, s, d}, n);
    if (n == 16 || (n == 8 && c[1])) begin
      if (s != 2'h0 && (c == DPW_CMD_NVWR || c == DPW_CMD_COPY)) x_store++;
      for (int p = 0; p < 2; p++) begin
        if (s[p]) begin
          case (c)
            DPW_CMD_WIPER: ew[p] = d;
            DPW_CMD_NVWR:  en[p] = d;
            DPW_CMD_COPY:  en[p] = ew[p];
            default:       ew[p] = en[p];
          endcase
        end
      end
    end
    check_all();
  endtask

  // Power-up from a given stored image
  task automatic s_init(input logic [7:0] a, input logic [7:0] b);
    i_resetn = 1'b0;
    i_nv_a = a;
    i_nv_b = b;
    repeat (2) @(negedge i_clk);
    check("nv_a in reset", o_nv_a, DPW_MIDSCALE);
    i_resetn = 1'b1;
    for (int k = 0; k < INIT + 6 && o_ready !== 1'b1; k++) @(negedge i_clk);
    if (o_ready !== 1'b1) begin
      errors++;
      complete_run();
    end else begin
      ew = '{a, b};
      en = ew;
      check_all();
      check("standby idle", {7'h0, o_standby}, 8'h01);
    end
  endtask
  task automatic s_wiper();
    fork
      go(DPW_CMD_WIPER, 2'h1, 8'h5a, 16);
      begin
        repeat (20) @(negedge i_clk);
        check("standby busy", {7'h0, o_standby}, 8'h00);
      end
    join
    go(DPW_CMD_WIPER, 2'h2, 8'ha5, 16);
  endtask
  task automatic s_nvwr();
    go(DPW_CMD_NVWR, 2'h2, 8'h77, 16);
    go(DPW_CMD_NVWR, 2'h1, 8'h01, 16);
  endtask
  task automatic s_copy();
    go(DPW_CMD_COPY, 2'h3, 8'hff, 8);
    go(DPW_CMD_WIPER, 2'h1, 8'h21, 16);
    go(DPW_CMD_COPY, 2'h1, 8'h00, 16);
    go(DPW_CMD_WIPER, 2'h2, 8'h6b, 16);
    go(DPW_CMD_COPY, 2'h2, 8'h00, 8);
  endtask
  task automatic s_rest();
    go(DPW_CMD_NVWR, 2'h1, 8'h99, 16);
    go(DPW_CMD_REST, 2'h1, 8'h00, 16);
    go(DPW_CMD_NVWR, 2'h2, 8'h42, 16);
    go(DPW_CMD_REST, 2'h3, 8'h00, 8);
  endtask
  task automatic s_refuse();
    go(DPW_CMD_WIPER, 2'h1, 8'h3e, 12);
    go(DPW_CMD_NVWR, 2'h2, 8'h3e, 8);
    go(DPW_CMD_COPY, 2'h3, 8'h00, 5);
    go(DPW_CMD_WIPER, 2'h0, 8'he7, 16);
    go(DPW_CMD_NVWR, 2'h0, 8'he7, 16);
  endtask
  // Clock enable low freezes the synchronisers too, so a whole frame goes unseen
  task automatic s_freeze();
    i_ce = 1'b0;
    u_dpw_host.send({4'h0, DPW_CMD_NVWR, 2'h3, 8'hd2}, 16);
    i_ce = 1'b1;
    repeat (4) @(negedge i_clk);
    check_all();
  endtask

  initial begin
    i_resetn = 1'b0;
    i_ce   = 1'b1;
    i_nv_a = 8'h00;
    i_nv_b = 8'h00;
    @(negedge i_clk);
    s_init(8'h3c, 8'hc5);
    s_wiper();
    s_nvwr();
    s_copy();
    s_rest();
    s_refuse();
    s_freeze();
    // Storage keeps what was last written, so power up again from it
    s_init(en[0], en[1]);
    complete_run();
  end
endmodule
